// [design/rac_map.svh]
// register offsets, field positions, reset values and timing counts for the alarm and time block
`ifndef RAC_MAP_SVH
`define RAC_MAP_SVH
`define RAC_ADDR_W 4
`define RAC_OFF_ALARM_CTRL 4'h0
`define RAC_OFF_TIME 4'h4
`define RAC_OFF_STATUS 4'h8
`define RAC_OFF_CAL_CMP 4'hc
`define RAC_BIT_ALM_EN 15
`define RAC_BIT_WRAP 14
`define RAC_BIT_PIV 13
`define RAC_BIT_UNSAFE 12
`define RAC_LSB_IVL 8
`define RAC_BIT_HALF 0
`define RAC_ALARM_RST 16'h0000
`define RAC_TIME_RST 24'h000000
`define RAC_SYNC_GUARD 32
`define RAC_RTC_HZ 32768
`define RAC_CLK_HZ 200000000
`define RAC_HALF_TICKS 16384
`endif

// [design/rac_pkg.sv]
// types shared by the alarm and time block
package rac_pkg;
  // alarm interval codes
  typedef enum logic [3:0] {
    RAC_IVL_HALF_SEC = 4'h0,
    RAC_IVL_SEC = 4'h1,
    RAC_IVL_10SEC = 4'h2,
    RAC_IVL_MIN = 4'h3,
    RAC_IVL_10MIN = 4'h4,
    RAC_IVL_HOUR = 4'h5,
    RAC_IVL_DAY = 4'h6,
    RAC_IVL_WEEK = 4'h7,
    RAC_IVL_MONTH = 4'h8,
    RAC_IVL_YEAR = 4'h9
  } rac_ivl_t;
  // time of day, bcd digits
  typedef struct packed {
    logic [3:0] hours_tens_digit;
    logic [3:0] hours_units_digit;
    logic [3:0] minutes_tens_digit;
    logic [3:0] minutes_units_digit;
    logic [3:0] seconds_tens_digit;
    logic [3:0] seconds_units_digit;
  } rac_time_t;
  // calendar date, bcd digits
  typedef struct packed {
    logic [3:0] mon10;
    logic [3:0] mon01;
    logic [3:0] day10;
    logic [3:0] day01;
    logic [3:0] wday;
  } rac_date_t;
  // alarm control fields
  typedef struct packed {
    logic en;
    logic wrap;
    logic pulse_initial_level;
    logic [3:0] ivl;
    logic [7:0] rpt;
  } rac_alarm_t;
endpackage : rac_pkg

// [design/rac_core.sv]
// alarm control and time value registers of the real-time clock
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "rac_map.svh"
// =====================================================================
// alarm control and time block
module rac_core
  import rac_pkg::*;
#(
  parameter int HALF_TICKS = `RAC_HALF_TICKS,
  parameter int GUARD = `RAC_SYNC_GUARD
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rtc_tick,
  input wire logic module_on,
  input wire logic value_write_unlock,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire rac_time_t alarm_time,
  input wire rac_date_t alarm_date,
  input wire rac_date_t cur_date,
  input wire logic leap_year,
  input wire logic second_tick,
  output logic alarm_pulse,
  output logic alarm_event
);
  initial
  begin
    if (HALF_TICKS <= GUARD || HALF_TICKS > 65535 || GUARD < 1)
      $error("rac_core: prescaler parameters out of range");
  end

  // =====================================================================
  // reset release
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic prst_n = rst_s2_q; // power-on reset copy; only reset the alarm sees

  // match of one field set; half-second tick handled outside
  function automatic logic fld_match(input logic [3:0] code, input rac_time_t t, input rac_time_t a,
                                     input rac_date_t d, input rac_date_t ad, input logic leap);
    logic m;
    m = 1'b1;
    if (code >= 4'h2) m = m & (t.seconds_units_digit == a.seconds_units_digit);
    if (code >= 4'h3) m = m & (t.seconds_tens_digit == a.seconds_tens_digit);
    if (code >= 4'h4) m = m & (t.minutes_units_digit == a.minutes_units_digit);
    if (code >= 4'h5) m = m & (t.minutes_tens_digit == a.minutes_tens_digit);
    if (code >= 4'h6) m = m & (t.hours_units_digit == a.hours_units_digit) & (t.hours_tens_digit == a.hours_tens_digit);
    if (code == 4'h7) m = m & (d.wday == ad.wday);
    if (code >= 4'h8) m = m & (d.day01 == ad.day01) & (d.day10 == ad.day10);
    if (code == 4'h9) m = m & (d.mon01 == ad.mon01) & (d.mon10 == ad.mon10);
    // feb 29 only exists in leap years, so a yearly alarm there is four-yearly
    if (code == 4'h9 && ad.mon10 == 4'h0 && ad.mon01 == 4'h2 && ad.day10 == 4'h2 && ad.day01 == 4'h9)
      m = m & leap;
    return m;
  endfunction : fld_match

  // =====================================================================
  // prescaler and half-second status
  logic [15:0] pre_q, pre_d;
  logic half_q, half_d;
  logic half_roll;
  logic sec_wr;
  always_comb
  begin
    pre_d = pre_q;
    half_d = half_q;
    half_roll = 1'b0;
    if (rtc_tick)
    begin
      if (pre_q == 16'(HALF_TICKS - 1))
      begin
        pre_d = 16'h0000;
        half_d = ~half_q;
        half_roll = 1'b1;
      end
      else
        pre_d = pre_q + 16'h0001;
    end
    if (sec_wr)
    begin
      half_d = 1'b0;
      pre_d = 16'h0000;
    end
  end
  always_ff @(posedge clk or negedge prst_n)
  begin
    if (!prst_n)
    begin
      pre_q <= 16'h0000;
      half_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      half_q <= half_d;
    end
  end
  // unsafe unless more than the guard distance from the next rollover
  wire logic unsafe = (16'(HALF_TICKS) - pre_q) <= 16'(GUARD);

  // =====================================================================
  // time value register
  rac_time_t time_q, time_d;
  always_comb
  begin
    time_d = time_q;
    sec_wr = 1'b0;
    // locked unless the unlock bit is set
    if (wr && addr == `RAC_OFF_TIME && value_write_unlock)
    begin
      time_d = wdata[31:8];
      sec_wr = 1'b1;
    end
    else if (second_tick)
      time_d = time_q; // time advance lives in the counter outside this block
  end
  always_ff @(posedge clk or negedge prst_n)
  begin
    if (!prst_n)
      time_q <= `RAC_TIME_RST;
    else
      time_q <= time_d;
  end

  // =====================================================================
  // alarm control and event generation
  rac_alarm_t alm_q, alm_d;
  logic pulse_q, pulse_d;
  logic evt;
  logic tick_ok;
  always_comb
  begin
    alm_d = alm_q;
    pulse_d = pulse_q;
    // half-second code fires on every rollover, others once per second
    tick_ok = (alm_q.ivl == RAC_IVL_HALF_SEC) ? half_roll : (half_roll && half_q);
    evt = alm_q.en && module_on && tick_ok && (alm_q.ivl <= 4'h9)
          && fld_match(alm_q.ivl, time_q, alarm_time, cur_date, alarm_date, leap_year);
    if (wr && addr == `RAC_OFF_ALARM_CTRL)
    begin
      alm_d.en = wdata[`RAC_BIT_ALM_EN];
      alm_d.wrap = wdata[`RAC_BIT_WRAP];
      alm_d.ivl = wdata[`RAC_LSB_IVL +: 4];
      alm_d.rpt = wdata[7:0];
      if (!alm_q.en)
      begin
        alm_d.pulse_initial_level = wdata[`RAC_BIT_PIV];
        pulse_d = wdata[`RAC_BIT_PIV];
      end
    end
    if (evt)
    begin
      pulse_d = ~pulse_q;
      if (alm_q.rpt != 8'h00)
        alm_d.rpt = alm_q.rpt - 8'h01;
      else if (alm_q.wrap)
        alm_d.rpt = 8'hff;
      else
      begin
        alm_d.rpt = 8'h00;
        alm_d.en = 1'b0; // hardware clear wins over a same-cycle write
      end
    end
  end
  always_ff @(posedge clk or negedge prst_n)
  begin
    if (!prst_n)
    begin
      alm_q <= rac_alarm_t'(15'(`RAC_ALARM_RST)); // bit 12 is live status, not stored
      pulse_q <= 1'b0;
    end
    else
    begin
      alm_q <= alm_d;
      pulse_q <= pulse_d;
    end
  end
  assign alarm_pulse = pulse_q;
  assign alarm_event = evt;

  // =====================================================================
  // read port, data one cycle after the strobe
  logic [31:0] rdata_q, rdata_d;
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd)
    begin
      case (addr)
        `RAC_OFF_ALARM_CTRL:
          // upper half zero; bit 13 shows pulse level while enabled
          rdata_d = {16'h0000, alm_q.en, alm_q.wrap, alm_q.en ? pulse_q : alm_q.pulse_initial_level, unsafe,
                     alm_q.ivl, alm_q.rpt};
        `RAC_OFF_TIME: rdata_d = {time_q, 8'h00};
        `RAC_OFF_STATUS: rdata_d = {31'h0, half_q};
        `RAC_OFF_CAL_CMP: rdata_d = {16'h0000, pre_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge prst_n)
  begin
    if (!prst_n)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end
  assign rdata = rdata_q;

  // =====================================================================
  // checks
  sequence last_evt_s;
    evt && alm_q.rpt == 8'h00 && !alm_q.wrap;
  endsequence
  en_clear_a: assert property (@(posedge clk) disable iff (!prst_n) last_evt_s |=> !alm_q.en)
    else $error("alarm enable not cleared");
  wrap_roll_a: assert property (@(posedge clk) disable iff (!prst_n)
    evt && alm_q.rpt == 8'h00 && alm_q.wrap |=> alm_q.rpt == 8'hff)
    else $error("counter did not wrap");
  cnt_dec_a: assert property (@(posedge clk) disable iff (!prst_n)
    evt && alm_q.rpt != 8'h00 && !(wr && addr == `RAC_OFF_ALARM_CTRL) |=> alm_q.rpt == $past(alm_q.rpt) - 8'h01)
    else $error("counter did not decrement");
  hold_zero_a: assert property (@(posedge clk) disable iff (!prst_n)
    last_evt_s |=> alm_q.rpt == 8'h00)
    else $error("counter left zero without wrap");
  ivl_rsvd_a: assert property (@(posedge clk) disable iff (!prst_n)
    alm_q.ivl > 4'h9 |-> !alarm_event)
    else $error("event on reserved interval code");
  pulse_tog_a: assert property (@(posedge clk) disable iff (!prst_n)
    alarm_event |=> pulse_q != $past(pulse_q))
    else $error("pulse did not toggle on event");
  time_wr_a: assert property (@(posedge clk) disable iff (!prst_n)
    wr && addr == `RAC_OFF_TIME && value_write_unlock |=> time_q == $past(wdata[31:8]))
    else $error("unlocked time write lost");
  time_rd_a: assert property (@(posedge clk) disable iff (!prst_n)
    rd && addr == `RAC_OFF_TIME |=> rdata == {$past(time_q), 8'h00})
    else $error("time read wrong");
  no_evt_off_a: assert property (@(posedge clk) disable iff (!prst_n) !alm_q.en |-> !alarm_event)
    else $error("event while disabled");
  piv_lock_a: assert property (@(posedge clk) disable iff (!prst_n)
    alm_q.en && !evt |=> pulse_q == $past(pulse_q))
    else $error("pulse level changed without event");
  unsafe_rd_a: assert property (@(posedge clk) disable iff (!prst_n)
    rd && addr == `RAC_OFF_ALARM_CTRL |=> rdata[`RAC_BIT_UNSAFE] == $past(unsafe) && rdata[31:16] == 16'h0)
    else $error("alarm control read wrong");
  time_lock_a: assert property (@(posedge clk) disable iff (!prst_n)
    !value_write_unlock |=> time_q == $past(time_q))
    else $error("time written while locked");
  half_clr_a: assert property (@(posedge clk) disable iff (!prst_n) sec_wr |=> !half_q)
    else $error("half-second flag not cleared");
  piv_wr_a: assert property (@(posedge clk) disable iff (!prst_n)
    wr && addr == `RAC_OFF_ALARM_CTRL && !alm_q.en && !evt |=> pulse_q == $past(wdata[`RAC_BIT_PIV]))
    else $error("pulse start level not loaded");
endmodule : rac_core

// [tb/rtc_alarm_control_and_time_tb_top.sv]
// self-checking bench for the alarm control and time block
module rtc_alarm_control_and_time_tb_top;
  import rac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, rtc_tick, on, unl, wr, rd, leap, live, alarm_pulse, alarm_event;
  logic en, wrap, pulse_initial_level, pulse, ev, unsafe;
  logic [3:0] addr, ivl;
  logic [3:0] tbl[4] = '{4'h0, 4'h4, 4'h8, 4'hc};
  logic [7:0] rpt, orpt;
  logic owrap;
  logic [23:0] tm;
  logic [31:0] wdata, rdata, exp_rd;
  rac_time_t alarm_time;
  rac_date_t a_date;
  int bad_count, checks_done, pre, half;
  // short prescaler and guard keep each half second near 128 cycles
  rac_core #(.HALF_TICKS(64), .GUARD(4)) DUT (.clk(clk), .rst_n(rst_n), .rtc_tick(rtc_tick),
    .module_on(on), .value_write_unlock(unl), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .alarm_time(alarm_time), .alarm_date(a_date), .cur_date(a_date),
    .leap_year(leap), .second_tick(1'b0), .alarm_pulse(alarm_pulse), .alarm_event(alarm_event));
  // =====================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // one bus cycle, signals move just after the edge
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask : bus
  // random traffic; time writes kept rare since they restart the prescaler
  task automatic rnd();
    int r;
    r = $urandom % 512;
    if (r < 32)
      bus(1'b0, 1'b1, tbl[r % 4], 32'h0);
    else if (r == 32)
      bus(1'b1, 1'b0, 4'h4, {24'h235959, 8'($urandom)});
    else if (r == 33 && !unsafe)
      bus(1'b1, 1'b0, 4'h0, {16'($urandom), en, wrap, 1'($urandom), 1'b0, ivl, rpt});
    else
      bus(1'b0, 1'b0, 4'h0, 32'h0);
  endtask : rnd
  // control writes wait for a safe window, then traffic runs
  task automatic arm(input logic [15:0] v);
    while (unsafe)
      bus(1'b0, 1'b0, 4'h0, 32'h0);
    bus(1'b1, 1'b0, 4'h0, {16'hffff, v});
    repeat (900)
      rnd();
  endtask : arm
  // =====================================================================
  // reference model, stepped on the edges the design samples
  always @(posedge clk)
  begin
    unsafe = (64 - pre) <= 4;
    ev = live && en && on && rtc_tick && pre == 63 && (ivl == 4'h0 || (ivl <= 4'h9 && half == 1
      && !(ivl == 4'h9 && a_date[19:4] == 16'h0229 && !leap)));
    if (live)
    begin
      chk(alarm_event, ev);
      chk(rdata, exp_rd);
      chk(alarm_pulse, pulse);
    end
    exp_rd = 0;
    if (rd && addr == 4'h0)
      exp_rd = {16'h0, en, wrap, en ? pulse : pulse_initial_level, unsafe, ivl, rpt};
    if (rd && addr == 4'h4)
      exp_rd = {tm, 8'h0};
    if (rd && addr == 4'h8)
      exp_rd = half;
    if (rd && addr == 4'hc)
      exp_rd = pre;
    // event works on the counter seen before any same-cycle write
    orpt = rpt;
    owrap = wrap;
    if (wr && addr == 4'h0)
    begin
      if (!en)
      begin
        pulse_initial_level = wdata[13];
        pulse = wdata[13];
      end
      {en, wrap, ivl, rpt} = {wdata[15:14], wdata[11:0]};
    end
    if (wr && addr == 4'h4 && unl)
    begin
      tm = wdata[31:8];
      pre = 0;
      half = 0;
    end
    else if (rtc_tick && live)
    begin
      half = half ^ (pre == 63);
      pre = (pre + 1) % 64;
    end
    if (ev)
    begin
      pulse = !pulse;
      if (orpt == 0 && !owrap)
        en = 0;
      rpt = (orpt != 0 || owrap) ? orpt - 8'h01 : 8'h00;
    end
  end
  // =====================================================================
  // stimulus
  always @(posedge clk)
    rtc_tick <= live ? 1'($urandom % 2) : 1'b0;
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, well beyond the expected run
  initial
  begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(41));
    {rst_n, rtc_tick, unl, wr, rd, leap, live, en, wrap, pulse_initial_level, pulse} = 0;
    {addr, ivl, rpt, tm, wdata, exp_rd, pre, half, bad_count, checks_done} = 0;
    on = 1;
    alarm_time = 24'h235959;
    a_date = 20'h03153;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    live <= 1;
    for (int i = 0; i < 4; i++)
      bus(1'b0, 1'b1, tbl[i], 32'h0);
    bus(1'b1, 1'b0, 4'h4, 32'h235959ff);
    bus(1'b0, 1'b1, 4'h4, 32'h0);
    unl <= 1;
    bus(1'b1, 1'b0, 4'h4, 32'h235959ff);
    bus(1'b0, 1'b1, 4'h8, 32'h0);
    bus(1'b0, 1'b1, 4'h2, 32'h0);
    for (int c = 0; c < 10; c++)
      arm({3'b100 | 3'(c % 2) << 1, 1'b0, 4'(c), 8'h01});
    bus(1'b0, 1'b1, 4'h0, 32'h0);
    bus(1'b0, 1'b1, 4'h0, 32'h0);
    on <= 0;
    arm(16'h8000);
    on <= 1;
    a_date <= 20'h02293;
    arm(16'h8901);
    leap <= 1;
    arm(16'h8901);
    arm(16'hc000);
    wrap_up();
  end
endmodule : rtc_alarm_control_and_time_tb_top
